// File: mic_pkg.sv
// mic_pkg: shared constants and types of the interrupt controller
package mic_pkg;
  // ****************************************
  // register map and widths
  // ****************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int PIN_N = 6;
  localparam int ANA_N = 4;
  localparam int EXT_PIN_IDX = 2;
  localparam logic [2:0] ADDR_IRQ_CTRL = 3'h0;
  localparam logic [2:0] ADDR_PIN_CHANGE_SEL = 3'h1;
  localparam logic [2:0] ADDR_PERIPH_FLAGS = 3'h2;
  localparam logic [2:0] ADDR_PERIPH_ENABLES = 3'h3;
  localparam logic [2:0] ADDR_OPTION = 3'h4;
  localparam logic [2:0] ADDR_ANALOG_SEL = 3'h5;
  // ****************************************
  // reset values and implemented-bit masks
  // ****************************************
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_CHANGE_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] ANALOG_RST = 8'h0F;
  localparam logic [7:0] PIN_CHANGE_MASK = 8'h3F;
  localparam logic [7:0] PERIPH_MASK = 8'h6B;
  localparam logic [7:0] ANALOG_MASK = 8'h0F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_TIMER0_IRQ_ENABLE = 5;
  localparam int B_EXT_PIN_IRQ_ENABLE = 4;
  localparam int B_PCIE = 3;
  localparam int B_TIMER0_IRQ_FLAG = 2;
  localparam int B_EXT_PIN_IRQ_FLAG = 1;
  localparam int B_PCIF = 0;
  localparam int B_ADC = 6;
  localparam int B_CAPCOMP = 5;
  localparam int B_COMP = 3;
  localparam int B_TMR2 = 1;
  localparam int B_TMR1 = 0;
  localparam int B_EDGE_SEL = 6;
  // ****************************************
  // vector and instruction-cycle phases
  // ****************************************
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_VECT = 4'b0100,
    ST_WAKE = 4'b1000
  } mic_seq_state_t;
endpackage

// File: mic_edge_det.sv
// mic_edge_det: registered sampler giving rise and fall pulses per bit
`timescale 1ns/100ps
`default_nettype none
module mic_edge_det #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // sampled level and update strobe
  input wire logic [W-1:0] level_in,
  input wire logic upd_in,
  // edge pulses
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] prev_r;

  // previous level only moves when sampling is open
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r <= '0;
    end else if (upd_in) begin
      prev_r <= level_in;
    end
  end

  // edges seen only while sampling is open, so a held edge is not lost
  assign rise_out = {W{upd_in}} & level_in & ~prev_r;
  assign fall_out = {W{upd_in}} & ~level_in & prev_r;
endmodule
`default_nettype wire

// File: mic_vector_seq.sv
// mic_vector_seq: instruction-cycle sequencer that decides when to vector
`timescale 1ns/100ps
`default_nettype none
module mic_vector_seq (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // core timing and request
  input wire logic cyc_end_in,
  input wire logic req_in,
  input wire logic asleep_in,
  // vector pulse and state
  output logic take_out,
  output mic_pkg::mic_seq_state_t state_out
);
  mic_pkg::mic_seq_state_t state_r;
  mic_pkg::mic_seq_state_t state_nxt;
  logic take_r;

  // next state at each instruction-cycle end
  always_comb begin
    state_nxt = state_r;
    if (cyc_end_in) begin
      case (state_r)
        mic_pkg::ST_IDLE: begin
          if (req_in && asleep_in) begin
            state_nxt = mic_pkg::ST_WAKE;
          end else if (req_in) begin
            state_nxt = mic_pkg::ST_HOLD;
          end
        end
        mic_pkg::ST_HOLD: begin
          state_nxt = req_in ? mic_pkg::ST_VECT : mic_pkg::ST_IDLE;
        end
        mic_pkg::ST_VECT: begin
          state_nxt = mic_pkg::ST_IDLE;
        end
        mic_pkg::ST_WAKE: begin
          // the instruction after sleep runs, then the vector follows
          if (!asleep_in) begin
            state_nxt = req_in ? mic_pkg::ST_VECT : mic_pkg::ST_IDLE;
          end
        end
        default: begin
          state_nxt = mic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= mic_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one-clock vector pulse, dropped if the request was withdrawn
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      take_r <= 1'b0;
    end else begin
      take_r <= cyc_end_in && (state_r == mic_pkg::ST_VECT) && req_in;
    end
  end

  assign take_out = take_r;
  assign state_out = state_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_hold_with_req;
    (state_r == mic_pkg::ST_HOLD) && cyc_end_in && req_in;
  endsequence
  sequence s_vect_pending;
    (state_r == mic_pkg::ST_VECT) [*4] ##0 cyc_end_in;
  endsequence
  AST_HOLD_LEADS_TO_VECT: assert property (@(posedge clk_in) disable iff (rst_in)
    s_hold_with_req |=> s_vect_pending)
    else $error("hold with request did not reach the vector cycle");
  AST_ABORT_ON_DROP: assert property (@(posedge clk_in) disable iff (rst_in)
    ((state_r == mic_pkg::ST_HOLD) && cyc_end_in && !req_in) |=> !take_r [*4])
    else $error("vector taken after the request was withdrawn");
endmodule
`default_nettype wire

// File: mic_irq_ctrl.sv
// mic_irq_ctrl: interrupt controller top with flags, enables and vectoring
//
// Notes on behaviour
// - eight sources feed eight flags
// - request needs global enable, flag, enable
// - reset clears the global enable
// - vectoring clears global enable, pushes, loads 0004h
// - return from handler sets global enable
// - external events serviced three to four cycles later
// - flags set whatever the enables are
// - clearing global enable blocks next-cycle vector
// - pin edge polarity follows edge select
// - pin wakes sleep only if enabled
// - analog pins read zero, no interrupt
// - timer0 wrap FFh to 00h sets flag
// - masked pin change sets change flag
// - change during port access may drop
// - flags split between control and peripheral registers
// - pin flag set only in Q4-Q1
// - after wake run next instruction, then vector
// - only the return address is saved
// - interrupt wake with global enable vectors 0004h
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // port pins and timer0
  input wire logic [5:0] GPIO_PINS_IN,
  input wire logic PORT_ACCESS_IN,
  input wire logic [7:0] TIMER0_COUNT_IN,
  output logic [5:0] DIGITAL_PINS_OUT,
  // peripheral event pulses
  input wire logic ADC_DONE_IN,
  input wire logic COMPARATOR_EVT_IN,
  input wire logic TIMER1_OVF_IN,
  input wire logic TIMER2_MATCH_IN,
  input wire logic CAPCOMP_EVT_IN,
  // core sequencer
  input wire logic RETURN_FROM_IRQ_IN,
  input wire logic SLEEP_IN,
  input wire logic [12:0] RETURN_PC_IN,
  output logic IRQ_REQ_OUT,
  output logic WAKE_OUT,
  output logic VECTOR_TAKE_OUT,
  output logic [12:0] VECTOR_ADDR_OUT,
  output logic STACK_PUSH_OUT,
  output logic [12:0] STACK_DATA_OUT,
  output logic [1:0] Q_PHASE_OUT
);
  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] irq_control_reg_r;
  logic [7:0] irq_control_reg_nxt;
  logic [7:0] pin_change_mask_r;
  logic [7:0] periph_irq_flags_reg_r;
  logic [7:0] periph_irq_flags_reg_nxt;
  logic [7:0] periph_irq_enables_reg_r;
  logic [7:0] option_r;
  logic [7:0] analog_select_reg_r;
  logic [7:0] rdata_r;
  logic [7:0] timer0_prev_r;
  logic [5:0] dig_pins_r;
  logic [5:0] dig_pins;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic [0:0] ext_rise;
  logic [0:0] ext_fall;
  logic [12:0] stack_data_r;
  logic [12:0] vector_addr_r;
  logic [1:0] q_phase_r;
  logic wr_ctrl;
  logic wr_flags;
  logic timer0_wrap;
  logic ext_sample_open;
  logic ext_edge;
  logic pin_change;
  logic [7:0] periph_set;
  logic [7:0] ctrl_set;
  logic periph_pending;
  logic core_pending;
  logic any_pending;
  logic cyc_end;
  logic take;
  logic seq_req;
  mic_pkg::mic_seq_state_t seq_state;

  // ****************************************
  // instruction-cycle phase
  // ****************************************
  // four clocks per instruction cycle, Q1 through Q4
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q_phase_r <= mic_pkg::PH_Q1;
    end else begin
      q_phase_r <= 2'(q_phase_r + mic_pkg::PH_STEP);
    end
  end

  assign cyc_end = (q_phase_r == mic_pkg::PH_Q4);
  assign Q_PHASE_OUT = q_phase_r;

  // ****************************************
  // event detection
  // ****************************************
  // analog pins read as zero on the digital side
  assign dig_pins = GPIO_PINS_IN & ~{2'h0, analog_select_reg_r[mic_pkg::ANA_N-1:0]};

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dig_pins_r <= 6'h00;
    end else begin
      dig_pins_r <= dig_pins;
    end
  end

  assign DIGITAL_PINS_OUT = dig_pins_r;

  // external pin sampled only across Q4 and Q1
  assign ext_sample_open = (q_phase_r == mic_pkg::PH_Q4) || (q_phase_r == mic_pkg::PH_Q1);

  mic_edge_det #(
    .W(1)
  ) u_ext_edge (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .level_in(dig_pins[mic_pkg::EXT_PIN_IDX]),
    .upd_in(ext_sample_open),
    .rise_out(ext_rise),
    .fall_out(ext_fall)
  );

  // polarity picked by the edge-select bit
  assign ext_edge = option_r[mic_pkg::B_EDGE_SEL] ? ext_rise[0] : ext_fall[0];

  mic_edge_det #(
    .W(mic_pkg::PIN_N)
  ) u_pin_edge (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .level_in(dig_pins),
    .upd_in(1'b1),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // masked change, lost when it meets a core port access
  assign pin_change = |((pin_rise | pin_fall) & pin_change_mask_r[mic_pkg::PIN_N-1:0])
                      && !PORT_ACCESS_IN;

  // timer0 wrap from all ones to zero
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      timer0_prev_r <= mic_pkg::BYTE_ZERO;
    end else begin
      timer0_prev_r <= TIMER0_COUNT_IN;
    end
  end

  assign timer0_wrap = (timer0_prev_r == mic_pkg::BYTE_ONES) &&
                       (TIMER0_COUNT_IN == mic_pkg::BYTE_ZERO);

  // flag set vectors, independent of any enable
  always_comb begin
    ctrl_set = 8'h00;
    ctrl_set[mic_pkg::B_EXT_PIN_IRQ_FLAG] = ext_edge;
    ctrl_set[mic_pkg::B_PCIF] = pin_change;
    ctrl_set[mic_pkg::B_TIMER0_IRQ_FLAG] = timer0_wrap;
    periph_set = 8'h00;
    periph_set[mic_pkg::B_ADC] = ADC_DONE_IN;
    periph_set[mic_pkg::B_COMP] = COMPARATOR_EVT_IN;
    periph_set[mic_pkg::B_TMR1] = TIMER1_OVF_IN;
    periph_set[mic_pkg::B_TMR2] = TIMER2_MATCH_IN;
    periph_set[mic_pkg::B_CAPCOMP] = CAPCOMP_EVT_IN;
  end

  // ****************************************
  // register writes
  // ****************************************
  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == mic_pkg::ADDR_IRQ_CTRL);
  assign wr_flags = REG_WR_IN && (REG_ADDR_IN == mic_pkg::ADDR_PERIPH_FLAGS);

  // control register: software write, then hardware sets win over clears, except that a take clear of the global enable wins over the return set
  always_comb begin
    irq_control_reg_nxt = wr_ctrl ? REG_WDATA_IN : irq_control_reg_r;
    irq_control_reg_nxt = irq_control_reg_nxt | ctrl_set;
    if (RETURN_FROM_IRQ_IN) begin
      irq_control_reg_nxt[mic_pkg::B_GIE] = 1'b1;
    end
    if (take) begin
      irq_control_reg_nxt[mic_pkg::B_GIE] = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_control_reg_r <= mic_pkg::IRQ_CTRL_RST;
    end else begin
      irq_control_reg_r <= irq_control_reg_nxt;
    end
  end

  // peripheral flags, set wins over a software clear
  assign periph_irq_flags_reg_nxt =
    ((wr_flags ? REG_WDATA_IN : periph_irq_flags_reg_r) | periph_set) & mic_pkg::PERIPH_MASK;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      periph_irq_flags_reg_r <= mic_pkg::PERIPH_RST;
    end else begin
      periph_irq_flags_reg_r <= periph_irq_flags_reg_nxt;
    end
  end

  // plain configuration registers
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pin_change_mask_r <= mic_pkg::PIN_CHANGE_RST;
      periph_irq_enables_reg_r <= mic_pkg::PERIPH_RST;
      option_r <= mic_pkg::OPTION_RST;
      analog_select_reg_r <= mic_pkg::ANALOG_RST;
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        mic_pkg::ADDR_PIN_CHANGE_SEL: begin
          pin_change_mask_r <= REG_WDATA_IN & mic_pkg::PIN_CHANGE_MASK;
        end
        mic_pkg::ADDR_PERIPH_ENABLES: begin
          periph_irq_enables_reg_r <= REG_WDATA_IN & mic_pkg::PERIPH_MASK;
        end
        mic_pkg::ADDR_OPTION: begin
          option_r <= REG_WDATA_IN;
        end
        mic_pkg::ADDR_ANALOG_SEL: begin
          analog_select_reg_r <= REG_WDATA_IN & mic_pkg::ANALOG_MASK;
        end
        default: begin
          option_r <= option_r;
        end
      endcase
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // data stand only in the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_r <= mic_pkg::BYTE_ZERO;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        mic_pkg::ADDR_IRQ_CTRL: rdata_r <= irq_control_reg_r;
        mic_pkg::ADDR_PIN_CHANGE_SEL: rdata_r <= pin_change_mask_r;
        mic_pkg::ADDR_PERIPH_FLAGS: rdata_r <= periph_irq_flags_reg_r;
        mic_pkg::ADDR_PERIPH_ENABLES: rdata_r <= periph_irq_enables_reg_r;
        mic_pkg::ADDR_OPTION: rdata_r <= option_r;
        mic_pkg::ADDR_ANALOG_SEL: rdata_r <= analog_select_reg_r;
        default: rdata_r <= mic_pkg::BYTE_ZERO;
      endcase
    end else begin
      rdata_r <= mic_pkg::BYTE_ZERO;
    end
  end

  assign REG_RDATA_OUT = rdata_r;

  // ****************************************
  // request and wake
  // ****************************************
  // peripheral sources pass the peripheral enable first
  assign periph_pending = irq_control_reg_r[mic_pkg::B_PERIPHERAL_IRQ_ENABLE] &&
                          |(periph_irq_flags_reg_r & periph_irq_enables_reg_r);
  assign core_pending =
    (irq_control_reg_r[mic_pkg::B_TIMER0_IRQ_FLAG] && irq_control_reg_r[mic_pkg::B_TIMER0_IRQ_ENABLE]) ||
    (irq_control_reg_r[mic_pkg::B_EXT_PIN_IRQ_FLAG] && irq_control_reg_r[mic_pkg::B_EXT_PIN_IRQ_ENABLE]) ||
    (irq_control_reg_r[mic_pkg::B_PCIF] && irq_control_reg_r[mic_pkg::B_PCIE]);
  assign any_pending = core_pending || periph_pending;

  // flags stay pending while the global enable is clear
  assign IRQ_REQ_OUT = irq_control_reg_r[mic_pkg::B_GIE] && any_pending;

  // wake needs the source enable, not the global enable
  assign WAKE_OUT = SLEEP_IN && any_pending;

  // a software clear of the global enable this cycle cancels the vector
  assign seq_req = IRQ_REQ_OUT && irq_control_reg_nxt[mic_pkg::B_GIE];

  mic_vector_seq u_seq (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .cyc_end_in(cyc_end),
    .req_in(seq_req),
    .asleep_in(SLEEP_IN),
    .take_out(take),
    .state_out(seq_state)
  );

  // ****************************************
  // vector and stack push
  // ****************************************
  // only the return address is captured, nothing else is saved
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stack_data_r <= 13'h0000;
      vector_addr_r <= 13'h0000;
    end else if (seq_state == mic_pkg::ST_VECT) begin
      stack_data_r <= RETURN_PC_IN;
      vector_addr_r <= mic_pkg::IRQ_VECTOR;
    end
  end

  assign STACK_DATA_OUT = stack_data_r;
  assign VECTOR_ADDR_OUT = vector_addr_r;
  assign VECTOR_TAKE_OUT = take;
  assign STACK_PUSH_OUT = take;

  // ****************************************
  // checks
  // ****************************************
  sequence s_ext_armed;
    ext_edge && irq_control_reg_r[mic_pkg::B_GIE] && irq_control_reg_r[mic_pkg::B_EXT_PIN_IRQ_ENABLE] &&
    !SLEEP_IN && (seq_state == mic_pkg::ST_IDLE);
  endsequence
  sequence s_gie_held;
    irq_control_reg_r[mic_pkg::B_GIE] && !wr_ctrl;
  endsequence

  AST_REQ_NEEDS_GIE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !irq_control_reg_r[mic_pkg::B_GIE] |-> !IRQ_REQ_OUT)
    else $error("request raised with global enable clear");
  AST_TAKE_CLEARS_GIE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    take |=> !irq_control_reg_r[mic_pkg::B_GIE] && (VECTOR_ADDR_OUT == mic_pkg::IRQ_VECTOR))
    else $error("global enable or vector wrong after servicing");
  AST_RETURN_SETS_GIE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (RETURN_FROM_IRQ_IN && !take) |=> irq_control_reg_r[mic_pkg::B_GIE])
    else $error("return from handler did not set global enable");
  AST_EXT_LATENCY: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    s_ext_armed ##1 s_gie_held [*3] |-> ##[1:16] take)
    else $error("external interrupt not serviced in time");
  AST_FLAG_IGNORES_ENABLE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (|periph_set) |=> |(periph_irq_flags_reg_r & $past(periph_set)))
    else $error("peripheral flag not set by its event");
  AST_GIE_DROP_BLOCKS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    take |-> $past(irq_control_reg_r[mic_pkg::B_GIE]) && irq_control_reg_r[mic_pkg::B_GIE])
    else $error("vector taken while global enable clear");
  AST_EXT_PHASE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    ($rose(irq_control_reg_r[mic_pkg::B_EXT_PIN_IRQ_FLAG]) && !$past(wr_ctrl)) |->
      ($past(q_phase_r) == mic_pkg::PH_Q4) || ($past(q_phase_r) == mic_pkg::PH_Q1))
    else $error("pin flag set outside Q4-Q1");
  AST_TIMER0_WRAP: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    timer0_wrap |=> irq_control_reg_r[mic_pkg::B_TIMER0_IRQ_FLAG])
    else $error("timer0 wrap did not set its flag");
  AST_ANALOG_ZERO: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    |($past(analog_select_reg_r[3:0]) & DIGITAL_PINS_OUT[3:0]) |-> 1'b0)
    else $error("analog pin read non-zero");
  AST_WAKE_NEEDS_ENABLE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (WAKE_OUT && !periph_pending) |-> core_pending && SLEEP_IN)
    else $error("wake without an enabled source");
endmodule
`default_nettype wire

// File: mic_core_model.sv
// mic_core_model: core sequencer stand-in facing the controller
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // controller side
  input wire logic take_in,
  input wire logic req_in,
  input wire logic wake_in,
  // bench commands
  input wire logic ret_req_in,
  input wire logic sleep_req_in,
  // core outputs
  output logic ret_out,
  output logic sleep_out,
  output logic [12:0] pc_out
);
  logic in_isr_r;
  // the core needs a few clocks to restart after a wake request
  logic [3:0] wake_sh_r;
  // pc frozen while a request waits or asleep; return only inside a handler
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_out <= 13'h0000;
      in_isr_r <= 1'b0;
      ret_out <= 1'b0;
      sleep_out <= 1'b0;
      wake_sh_r <= 4'h0;
    end else begin
      if (take_in) begin
        pc_out <= mic_pkg::IRQ_VECTOR;
      end else if (!req_in && !sleep_out) begin
        pc_out <= pc_out + 13'h0001;
      end
      in_isr_r <= take_in | (in_isr_r & ~ret_out);
      ret_out <= ret_req_in & in_isr_r & ~ret_out;
      wake_sh_r <= {wake_sh_r[2:0], wake_in};
      sleep_out <= sleep_req_in | (sleep_out & ~wake_sh_r[3]);
    end
  end
endmodule
`default_nettype wire

// File: mic_irq_ctrl_bench.sv
// mic_irq_ctrl_bench: self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mic_irq_ctrl_bench;
  logic clk, rst, wr, rd_s, pacc, ret_req, sleep_req, ret, slp, req, wake, take, push;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, t0, v;
  logic [5:0] pins, dig;
  logic [4:0] ev;
  logic [12:0] rpc, vaddr, sdata, s;
  logic [1:0] q;
  int err_count, checks, cyc, c, i;
  integer seed;
  // design and core stand-in
  mic_irq_ctrl dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .GPIO_PINS_IN(pins),
    .PORT_ACCESS_IN(pacc), .TIMER0_COUNT_IN(t0), .DIGITAL_PINS_OUT(dig), .ADC_DONE_IN(ev[0]),
    .COMPARATOR_EVT_IN(ev[1]), .TIMER1_OVF_IN(ev[2]), .TIMER2_MATCH_IN(ev[3]),
    .CAPCOMP_EVT_IN(ev[4]), .RETURN_FROM_IRQ_IN(ret), .SLEEP_IN(slp), .RETURN_PC_IN(rpc),
    .IRQ_REQ_OUT(req), .WAKE_OUT(wake), .VECTOR_TAKE_OUT(take), .VECTOR_ADDR_OUT(vaddr),
    .STACK_PUSH_OUT(push), .STACK_DATA_OUT(sdata), .Q_PHASE_OUT(q));
  mic_core_model core_u (.clk_in(clk), .rst_in(rst), .take_in(take), .req_in(req),
    .wake_in(wake), .ret_req_in(ret_req), .sleep_req_in(sleep_req), .ret_out(ret),
    .sleep_out(slp), .pc_out(rpc));
  // expected reset value of each register index
  function automatic logic [7:0] exp_rst(input logic [2:0] a);
    case (a)
      mic_pkg::ADDR_OPTION: return mic_pkg::OPTION_RST;
      mic_pkg::ADDR_ANALOG_SEL: return mic_pkg::ANALOG_RST;
      default: return mic_pkg::BYTE_ZERO;
    endcase
  endfunction
  // flag bit of each peripheral event input
  function automatic logic [7:0] ev_bit(input int k);
    logic [7:0] t[5] = '{8'h40, 8'h08, 8'h01, 8'h02, 8'h20};
    return t[k];
  endfunction
  // compare and count
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // register port cycles
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk({5'h00, rdata}, {5'h00, e}, m);
  endtask
  task automatic set_pins(input logic [5:0] p, input logic a);
    @(posedge clk);
    pins <= p;
    pacc <= a;
    @(posedge clk);
    pacc <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_take();
    c = 0;
    s = rpc;
    while (take !== 1'b1 && c < 40) begin
      s = rpc;
      @(negedge clk);
      c++;
    end
  endtask
  task automatic do_ret();
    @(posedge clk);
    ret_req <= 1'b1;
    repeat (2) @(posedge clk);
    ret_req <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    {rst, wr, rd_s, pacc, ret_req, sleep_req} = 6'b100000;
    {addr, wdata, t0, pins, ev} = '0;
    seed = 32'h9b9d;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd_chk(3'(i), exp_rst(3'(i)), "reset value");
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      ev <= 5'(1 << i);
      @(posedge clk);
      ev <= 5'h00;
      rd_chk(mic_pkg::ADDR_PERIPH_FLAGS, ev_bit(i), "periph flag");
      chk({12'h000, req}, 13'h0000, "no request");
      wr_reg(mic_pkg::ADDR_PERIPH_FLAGS, 8'h00);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      t0 <= 8'hFE + 8'(i % 3);
    end
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h04, "timer0 wrap");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h00);
    $display("test flags done");
    set_pins(6'h04, 1'b0);
    chk({7'h00, dig}, 13'h0000, "analog pin read");
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h00, "analog pin edge");
    set_pins(6'h00, 1'b0);
    wr_reg(mic_pkg::ADDR_ANALOG_SEL, 8'h00);
    set_pins(6'h04, 1'b0);
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h02, "rising edge");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h00);
    set_pins(6'h00, 1'b0);
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h00, "falling, rising selected");
    wr_reg(mic_pkg::ADDR_OPTION, 8'hBF);
    set_pins(6'h04, 1'b0);
    set_pins(6'h00, 1'b0);
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h02, "falling edge");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h00);
    wr_reg(mic_pkg::ADDR_OPTION, 8'hFF);
    wr_reg(mic_pkg::ADDR_PIN_CHANGE_SEL, 8'h10);
    set_pins(6'h20, 1'b0);
    set_pins(6'h30, 1'b1);
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h00, "unmasked or port access");
    set_pins(6'h20, 1'b0);
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h01, "pin change");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h00);
    wr_reg(mic_pkg::ADDR_PIN_CHANGE_SEL, 8'h00);
    $display("test pins done");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h90);
    @(posedge clk);
    pins <= 6'h24;
    wait_take();
    checks++;
    if (c < 10 || c > 17) begin
      err_count++;
      $display("wrong value at %0t: latency %0d clocks", $time, c);
    end
    chk(vaddr, mic_pkg::IRQ_VECTOR, "vector");
    chk(sdata, s, "stacked pc");
    chk({12'h000, push}, 13'h0001, "push");
    chk({11'h000, q}, 13'(mic_pkg::PH_Q1), "phase at take");
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h12, "enable cleared");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h10);
    do_ret();
    rd_chk(mic_pkg::ADDR_IRQ_CTRL, 8'h90, "return sets enable");
    $display("test vector done");
    wr_reg(mic_pkg::ADDR_PERIPH_ENABLES, 8'h01);
    @(posedge clk);
    ev <= 5'h04;
    @(posedge clk);
    ev <= 5'h00;
    @(negedge clk);
    chk({12'h000, req}, 13'h0000, "peripheral gate");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'hC0);
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h40);
    wait_take();
    chk(13'(c), 13'd40, "blocked take");
    rd_chk(mic_pkg::ADDR_PERIPH_FLAGS, 8'h01, "still pending");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'hC0);
    wait_take();
    chk({12'h000, take}, 13'h0001, "pending taken");
    wr_reg(mic_pkg::ADDR_PERIPH_FLAGS, 8'h00);
    do_ret();
    $display("test gating done");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h00);
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    set_pins(6'h20, 1'b0);
    set_pins(6'h24, 1'b0);
    chk({12'h000, wake}, 13'h0000, "no wake when disabled");
    wr_reg(mic_pkg::ADDR_IRQ_CTRL, 8'h90);
    set_pins(6'h20, 1'b0);
    @(posedge clk);
    pins <= 6'h24;
    c = 0;
    while (slp === 1'b1 && c < 60) begin
      @(negedge clk);
      c++;
    end
    wait_take();
    checks++;
    if (c < 4 || c > 39) begin
      err_count++;
      $display("wrong value at %0t: wake to vector %0d", $time, c);
    end
    chk(vaddr, mic_pkg::IRQ_VECTOR, "wake vector");
    $display("test sleep done");
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wr_reg(mic_pkg::ADDR_PERIPH_ENABLES, v);
      wr_reg(mic_pkg::ADDR_PIN_CHANGE_SEL, ~v);
      rd_chk(mic_pkg::ADDR_PERIPH_ENABLES, v & mic_pkg::PERIPH_MASK, "enables");
      rd_chk(mic_pkg::ADDR_PIN_CHANGE_SEL, ~v & mic_pkg::PIN_CHANGE_MASK, "mask");
    end
    $display("test random done");
    give_verdict();
  end
endmodule
`default_nettype wire
